// *** logic/stbt_pkg.sv ***
// Package for the sixteen-bit overflow timer: register map, fields, codes.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package stbt_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_FLAG = 8'h0C;
	localparam logic [7:0] OFS_ENABLE = 8'h10;
	localparam logic [7:0] OFS_COMPARE = 8'h14;
	localparam logic [7:0] OFS_CMP_MODE = 8'h18;
	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int CTL_WIDE = 7;
	localparam int CTL_OSC_RUN = 6;
	localparam int CTL_PRE_HI = 5;
	localparam int CTL_PRE_LO = 4;
	localparam int CTL_XOSC = 3;
	localparam int CTL_SYNC_BYP = 2;
	localparam int CTL_SRC = 1;
	localparam int CTL_ON = 0;
	localparam int FLAG_OVF = 0;
	localparam int EN_OVF = 0;
	localparam int ADC_EN_BIT = 1;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] CTL_WMASK = 8'hBF;
	localparam logic [3:0] CMP_MODE_TRIG = 4'hB;
	localparam logic [3:0] CMP_MODE_RST = 4'h0;
	localparam logic [15:0] COUNT_ONES = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COMPARE_RST = 16'hFFFF;
	localparam logic [2:0] PRE_ZERO = 3'h0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : stbt_pkg

// *** logic/stbt_count_mem.sv ***
// Counter storage: two bytes, byte write strobes, combinational read.
// Assumes the caller resolves every load and increment before writing here.
`timescale 1ns/1ps
module stbt_count_mem #(
	parameter int W = 16
) (
	input wire logic ref_clk,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// No reset: contents keep through every reset, start undefined at power.
	logic [W/2-1:0] lo_ff;
	logic [W/2-1:0] hi_ff;
	always_ff @(posedge ref_clk) begin
		if (wr_lo) begin
			lo_ff <= wdata[W/2-1:0];
		end
		if (wr_hi) begin
			hi_ff <= wdata[W-1:W/2];
		end
	end
	assign rdata = {hi_ff, lo_ff};
endmodule : stbt_count_mem

// *** logic/stbt_timer.sv ***
// Sixteen-bit up-counter with overflow flag, trigger reset and wide access.
// Assumes an APB master on ref_clk; ext_clk_in is an asynchronous pin.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module stbt_timer
	import stbt_pkg::*;
#(
	parameter int W = 16,
	parameter int PRE_W = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_tick,
	input wire logic ext_clk_in,
	input wire logic osc_run_in,
	input wire logic adc_enabled,
	output logic overflow_irq,
	output logic adc_start,
	output logic count_tick
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] ctl_ff, nxt_ctl;
	logic flag_ff, nxt_flag;
	logic irq_en_ff, nxt_irq_en;
	logic [7:0] hbuf_ff, nxt_hbuf;
	logic [W-1:0] cmp_ff, nxt_cmp;
	logic [3:0] mode_ff, nxt_mode;
	logic [PRE_W-1:0] pre_ff, nxt_pre;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic irq_ff, adc_ff, tick_ff, nxt_adc;
	logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
	logic run_s1_ff, run_s2_ff;
	logic [W-1:0] cnt;
	logic [W-1:0] cnt_wdata;
	logic cnt_wr_lo, cnt_wr_hi;

	stbt_count_mem #(.W(W)) u_mem (
		.ref_clk(ref_clk),
		.wr_lo(cnt_wr_lo),
		.wr_hi(cnt_wr_hi),
		.wdata(cnt_wdata),
		.rdata(cnt)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ----------------------------------------
	// Clock source and prescaler
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_s3_ff <= 1'b0;
			run_s1_ff <= 1'b0;
			run_s2_ff <= 1'b0;
		end else begin
			ext_s1_ff <= ext_clk_in;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
			run_s1_ff <= osc_run_in;
			run_s2_ff <= run_s1_ff;
		end
	end

	// Single clock design: the bypass bit is not decoded, the pin is always sampled twice,
	// so the bypass mode behaves exactly like sync mode.
	logic ext_rise, src_tick, pre_done, inc;
	logic [PRE_W-1:0] pre_lim;
	assign ext_rise = ext_s2_ff & ~ext_s3_ff;
	assign src_tick = ctl_ff[CTL_SRC] ? ext_rise : instr_tick;
	always_comb begin
		case (ctl_ff[CTL_PRE_HI:CTL_PRE_LO])
			2'h0: pre_lim = 3'h0;
			2'h1: pre_lim = 3'h1;
			2'h2: pre_lim = 3'h3;
			default: pre_lim = 3'h7;
		endcase
	end
	assign pre_done = (pre_ff == pre_lim);
	assign inc = ctl_ff[CTL_ON] & src_tick & pre_done;

	// ----------------------------------------
	// Bus decode and counter next state
	// ----------------------------------------
	logic acc, wr, rd, wide, match, trig;
	assign acc = psel & penable & ~pready_ff;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign wide = ctl_ff[CTL_WIDE];
	assign match = (cnt == cmp_ff);
	assign trig = (mode_ff == CMP_MODE_TRIG) & match & ctl_ff[CTL_ON] & src_tick & pre_done;

	logic wr_lo, wr_hi, mapped;
	assign wr_lo = wr & hit(paddr, OFS_COUNT_LOW);
	assign wr_hi = wr & hit(paddr, OFS_COUNT_HIGH);
	assign mapped = hit(paddr, OFS_COUNT_LOW) | hit(paddr, OFS_COUNT_HIGH) | hit(paddr, OFS_CONTROL)
		| hit(paddr, OFS_FLAG) | hit(paddr, OFS_ENABLE) | hit(paddr, OFS_COMPARE) | hit(paddr, OFS_CMP_MODE);

	always_comb begin
		cnt_wr_lo = 1'b0;
		cnt_wr_hi = 1'b0;
		cnt_wdata = cnt;
		nxt_pre = pre_ff;
		nxt_adc = 1'b0;
		if (wr_lo) begin
			cnt_wr_lo = 1'b1;
			cnt_wr_hi = wide;
			cnt_wdata = {(wide ? hbuf_ff : cnt[W-1:8]), pwdata[7:0]};
			nxt_pre = PRE_ZERO;
		end else if (wr_hi && !wide) begin
			cnt_wr_hi = 1'b1;
			cnt_wdata = {pwdata[7:0], cnt[7:0]};
		end else if (trig) begin
			cnt_wr_lo = 1'b1;
			cnt_wr_hi = 1'b1;
			cnt_wdata = COUNT_ZERO;
			nxt_pre = PRE_ZERO;
			nxt_adc = adc_enabled;
		end else if (ctl_ff[CTL_ON] && src_tick) begin
			nxt_pre = pre_done ? PRE_ZERO : PRE_W'(pre_ff + 1'b1);
			if (pre_done) begin
				cnt_wr_lo = 1'b1;
				cnt_wr_hi = 1'b1;
				cnt_wdata = W'(cnt + 1'b1);
			end
		end
	end

	// ----------------------------------------
	// Registers and APB answer
	// ----------------------------------------
	logic ovf;
	assign ovf = inc & ~trig & ~wr_lo & ~(wr_hi & ~wide) & (cnt == COUNT_ONES);

	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_ctl[CTL_OSC_RUN] = run_s2_ff;
		nxt_flag = flag_ff;
		nxt_irq_en = irq_en_ff;
		nxt_hbuf = hbuf_ff;
		nxt_cmp = cmp_ff;
		nxt_mode = mode_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = acc;
		nxt_pslverr = acc & ~mapped;
		if (wr) begin
			if (hit(paddr, OFS_CONTROL)) begin
				nxt_ctl = (pwdata[7:0] & CTL_WMASK) | (ctl_ff & ~CTL_WMASK);
			end else if (hit(paddr, OFS_COUNT_HIGH) && wide) begin
				nxt_hbuf = pwdata[7:0];
			end else if (hit(paddr, OFS_FLAG)) begin
				nxt_flag = pwdata[FLAG_OVF];
			end else if (hit(paddr, OFS_ENABLE)) begin
				nxt_irq_en = pwdata[EN_OVF];
			end else if (hit(paddr, OFS_COMPARE)) begin
				nxt_cmp = pwdata[W-1:0];
			end else if (hit(paddr, OFS_CMP_MODE)) begin
				nxt_mode = pwdata[3:0];
			end
		end
		if (ovf) begin
			nxt_flag = 1'b1;
		end
		if (rd) begin
			nxt_prdata = RDATA_ZERO;
			if (hit(paddr, OFS_COUNT_LOW)) begin
				nxt_prdata[7:0] = cnt[7:0];
				if (wide) begin
					nxt_hbuf = cnt[W-1:8];
				end
			end else if (hit(paddr, OFS_COUNT_HIGH)) begin
				nxt_prdata[7:0] = wide ? hbuf_ff : cnt[W-1:8];
			end else if (hit(paddr, OFS_CONTROL)) begin
				nxt_prdata[7:0] = ctl_ff;
			end else if (hit(paddr, OFS_FLAG)) begin
				nxt_prdata[FLAG_OVF] = flag_ff;
			end else if (hit(paddr, OFS_ENABLE)) begin
				nxt_prdata[EN_OVF] = irq_en_ff;
			end else if (hit(paddr, OFS_COMPARE)) begin
				nxt_prdata[W-1:0] = cmp_ff;
			end else if (hit(paddr, OFS_CMP_MODE)) begin
				nxt_prdata[3:0] = mode_ff;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctl_ff <= CONTROL_RST;
			flag_ff <= 1'b0;
			irq_en_ff <= 1'b0;
			hbuf_ff <= 8'h00;
			cmp_ff <= COMPARE_RST;
			mode_ff <= CMP_MODE_RST;
			pre_ff <= PRE_ZERO;
			prdata_ff <= RDATA_ZERO;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			irq_ff <= 1'b0;
			adc_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			ctl_ff <= nxt_ctl;
			flag_ff <= nxt_flag;
			irq_en_ff <= nxt_irq_en;
			hbuf_ff <= nxt_hbuf;
			cmp_ff <= nxt_cmp;
			mode_ff <= nxt_mode;
			pre_ff <= nxt_pre;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			irq_ff <= nxt_flag & nxt_irq_en;
			adc_ff <= nxt_adc;
			tick_ff <= inc;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign overflow_irq = irq_ff;
	assign adc_start = adc_ff;
	assign count_tick = tick_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_wrap;
		@(posedge ref_clk) disable iff (rst) (inc && !trig && !wr && cnt == COUNT_ONES) |=> (cnt == COUNT_ZERO);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
	property p_ovf_flag;
		@(posedge ref_clk) disable iff (rst) ovf |=> flag_ff;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");
	property p_irq;
		@(posedge ref_clk) disable iff (rst) overflow_irq == (flag_ff && irq_en_ff);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not flag and enable");
	property p_trig_clear;
		@(posedge ref_clk) disable iff (rst) (trig && !wr_lo && !wr_hi) |=> (cnt == COUNT_ZERO) && adc_start == $past(adc_enabled);
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear counter");
	property p_trig_noflag;
		@(posedge ref_clk) disable iff (rst) (trig && !flag_ff && !wr) |=> !flag_ff;
	endproperty
	a_trig_noflag: assert property (p_trig_noflag) else $error("trigger set overflow flag");
	property p_write_wins;
		@(posedge ref_clk) disable iff (rst) (trig && wr_lo) |=> (cnt[7:0] == $past(pwdata[7:0]));
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("write lost to trigger");
	property p_snap;
		@(posedge ref_clk) disable iff (rst) (rd && wide && hit(paddr, OFS_COUNT_LOW)) |=> (hbuf_ff == $past(cnt[W-1:8]));
	endproperty
	a_snap: assert property (p_snap) else $error("low read did not snapshot high");
	property p_wide_load;
		@(posedge ref_clk) disable iff (rst) (wr_lo && wide) |=> (cnt == {$past(hbuf_ff), $past(pwdata[7:0])});
	endproperty
	a_wide_load: assert property (p_wide_load) else $error("wide write not coherent");
	property p_hi_keep_pre;
		@(posedge ref_clk) disable iff (rst) (wr_hi && !src_tick) |=> (pre_ff == $past(pre_ff));
	endproperty
	a_hi_keep_pre: assert property (p_hi_keep_pre) else $error("high write touched prescaler");
	property p_hold;
		@(posedge ref_clk) disable iff (rst) (!ctl_ff[CTL_ON] && !wr_lo && !wr_hi) |-> !(cnt_wr_lo || cnt_wr_hi);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while stopped");
endmodule : stbt_timer

// *** bench/stbt_core_model.sv ***
// Far-side model: instruction-cycle pulse source and a free-running crystal pin.
// Assumes ref_clk from the bench; the crystal phase is unrelated to it.
`timescale 1ns/1ps
module stbt_core_model (
	input wire logic ref_clk,
	output logic instr_tick,
	output logic ext_clk_in
);
	logic [1:0] div_ff = 2'h0;

	// One instruction cycle per four system clocks
	assign instr_tick = (div_ff == 2'h3);

	always @(posedge ref_clk) begin
		div_ff <= div_ff + 2'h1;
	end

	// Crystal never stops, period 260 ns, not a multiple of ref_clk
	initial begin
		ext_clk_in = 1'b0;
		#7;
		forever #130 ext_clk_in = ~ext_clk_in;
	end
endmodule : stbt_core_model

// *** bench/stbt_timer_test.sv ***
// Bench for the sixteen-bit overflow timer: APB master, scenarios, verdict.
// Assumes stbt_timer and stbt_core_model compile alongside it.
`timescale 1ns/1ps
module stbt_timer_test
	import stbt_pkg::*;
();
	logic ref_clk, rst, psel, penable, pwrite, adc_en, osc_in, err;
	logic [7:0] paddr, hb, lb;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, itick, eclk, irq, adc_start, count_tick;
	logic [15:0] cmp;
	int miscompares, n_compared, c;

	stbt_core_model model (.ref_clk(ref_clk), .instr_tick(itick), .ext_clk_in(eclk));
	stbt_timer dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_tick(itick), .ext_clk_in(eclk), .osc_run_in(osc_in), .adc_enabled(adc_en),
		.overflow_irq(irq), .adc_start(adc_start), .count_tick(count_tick));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ------------
	// Tasks
	// ------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Idle edge first, so a release and a new setup never share a time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1);
		chk("pready wait", 2, n);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd);
	endtask : rchk

	// Second pass gives the spacing between two pulses in c
	task automatic gap(input bit on_adc);
		repeat (2) begin
			c = 0;
			do begin
				@(posedge ref_clk);
				c++;
			end while ((on_adc ? adc_start : count_tick) !== 1'b1 && c < 2000);
		end
	endtask : gap

	task automatic close_out();
		$display("Compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	initial begin
		#1000000;
		miscompares++;
		close_out();
	end

	// ------------
	// Scenarios
	// ------------
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		adc_en = 1'b0;
		osc_in = 1'b0;
		miscompares = 0;
		n_compared = 0;
		void'($urandom(66));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		rchk("control", OFS_CONTROL, 32'h0000_0000);
		rchk("compare", OFS_COMPARE, 32'h0000_FFFF);
		apb(1'b0, 8'hFC, 32'h0000_0000);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		wr(OFS_COUNT_HIGH, 32'h0000_00FF);
		wr(OFS_COUNT_LOW, 32'h0000_00FE);
		rchk("stopped", OFS_COUNT_LOW, 32'h0000_00FE);
		osc_in <= 1'($urandom);
		wr(OFS_CONTROL, 32'h0000_00FF);
		rchk("control ro", OFS_CONTROL, {24'h0, 1'b1, osc_in, 6'h3F});
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_COUNT_HIGH, 32'h0000_00FF);
		wr(OFS_COUNT_LOW, 32'h0000_00FE);
		wr(OFS_CONTROL, 32'h0000_0001);
		repeat (30) @(posedge ref_clk);
		rchk("wrap flag", OFS_FLAG, 1);
		rchk("wrapped high", OFS_COUNT_HIGH, 0);
		chk("irq masked", 0, irq);
		wr(OFS_ENABLE, 1);
		repeat (2) @(posedge ref_clk);
		chk("irq", 1, irq);
		wr(OFS_FLAG, 0);
		repeat (2) @(posedge ref_clk);
		chk("irq cleared", 0, irq);
		for (int ps = 0; ps < 4; ps++) begin
			wr(OFS_CONTROL, (ps << 4) | 1);
			gap(1'b0);
			chk("tick gap", 4 << ps, c);
		end
		wr(OFS_CONTROL, 32'h0000_0003);
		gap(1'b0);
		chk("ext gap", 1, c >= 10 && c <= 11);
		cmp = 16'($urandom_range(30, 3));
		adc_en <= 1'b1;
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_COMPARE, cmp);
		wr(OFS_CMP_MODE, CMP_MODE_TRIG);
		wr(OFS_COUNT_HIGH, 0);
		wr(OFS_COUNT_LOW, 0);
		wr(OFS_FLAG, 0);
		wr(OFS_CONTROL, 32'h0000_0001);
		gap(1'b1);
		chk("trigger period", (cmp + 1) * 4, c);
		rchk("no flag", OFS_FLAG, 0);
		adc_en <= 1'b0;
		gap(1'b1);
		chk("no conversion", 2000, c);
		// Corner: trigger exactly at all-ones, then a true wrap with the trigger off
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_COMPARE, COUNT_ONES);
		for (int m = 0; m < 2; m++) begin
			wr(OFS_CMP_MODE, m ? CMP_MODE_RST : CMP_MODE_TRIG);
			wr(OFS_COUNT_HIGH, 32'h0000_00FF);
			wr(OFS_COUNT_LOW, 32'h0000_00F0);
			wr(OFS_CONTROL, 32'h0000_0001);
			repeat (80) @(posedge ref_clk);
			wr(OFS_CONTROL, 32'h0000_0000);
			rchk("flag at ones", OFS_FLAG, m);
		end
		apb(1'b0, OFS_COUNT_LOW, 32'h0000_0000);
		lb = rd[7:0];
		wr(OFS_COUNT_HIGH, 32'h0000_0080);
		wr(OFS_FLAG, 0);
		rchk("preload high", OFS_COUNT_HIGH, 32'h0000_0080);
		rchk("preload low kept", OFS_COUNT_LOW, lb);
		rchk("flag cleared", OFS_FLAG, 0);
		hb = 8'($urandom);
		lb = 8'($urandom);
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_COUNT_HIGH, 32'h0000_005A);
		wr(OFS_COUNT_LOW, lb);
		wr(OFS_CONTROL, 32'h0000_0080);
		wr(OFS_COUNT_HIGH, hb);
		rchk("buffer", OFS_COUNT_HIGH, hb);
		rchk("wide low", OFS_COUNT_LOW, lb);
		rchk("snapshot", OFS_COUNT_HIGH, 32'h0000_005A);
		wr(OFS_COUNT_HIGH, hb);
		wr(OFS_COUNT_LOW, lb);
		wr(OFS_CONTROL, 32'h0000_0000);
		rchk("loaded high", OFS_COUNT_HIGH, hb);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rchk("kept low", OFS_COUNT_LOW, lb);
		rchk("kept high", OFS_COUNT_HIGH, hb);
		close_out();
	end
endmodule : stbt_timer_test
